// *** src/page_req_report.v ***
`timescale 1ns/1ps
`default_nettype none
`include "prq_consts.vh"
// records page requests into the memory queue and raises the page request event
module page_req_report #(
    parameter PTR_W = 8
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         ce_i,
    // page request message from the interconnect
    input  wire         req_valid_i,
    output reg          req_ready_o,
    input  wire [7:0]   req_bus_i,
    input  wire [7:0]   req_devfn_i,
    input  wire         req_pp_i,
    input  wire [19:0]  req_pasid_i,
    input  wire [51:0]  req_addr_i,
    input  wire [8:0]   req_group_index_i,
    input  wire         req_last_in_group_flag_i,
    input  wire         req_rdr_i,
    input  wire         req_wrr_i,
    input  wire         req_exr_i,
    input  wire         req_pmr_i,
    // descriptor write to memory
    output reg          mem_wr_o,
    output reg  [PTR_W-1:0] mem_idx_o,
    output wire [255:0] mem_data_o,
    input  wire         mem_ack_i,
    // event interrupt, sent directly
    output reg          irq_msg_o,
    input  wire         irq_done_i,
    // invalidation queue descriptor check
    input  wire         iq_dsc_valid_i,
    input  wire [6:0]   iq_dsc_type_i,
    output reg          iq_err_o,
    // register port
    input  wire [3:0]   reg_addr_i,
    input  wire [31:0]  reg_wdata_i,
    input  wire         reg_wr_i,
    input  wire         reg_rd_i,
    output reg  [31:0]  reg_rdata_o
);
    localparam S_IDLE  = 2'b00;
    localparam S_WRITE = 2'b01;
    localparam S_BUMP  = 2'b10;

    reg [1:0]       state_ff;
    reg [PTR_W-1:0] tail_ff;
    reg [PTR_W-1:0] head_ff;
    reg [PTR_W-1:0] last_ff;
    reg             ppr_ff;
    reg             pro_ff;
    reg             ip_ff;
    reg             im_ff;
    reg             dw_ff;
    reg             irq_fly_ff;
    reg             irq_want_ff;
    reg             rd_hold_ff;
    reg [3:0]       rd_addr_ff;
    reg             last_in_group_flag_drop_ff;
    wire            ack_s;
    wire [PTR_W-1:0] tail_inc;
    wire            q_full;
    wire            q_busy;
    wire            raise_evt;
    wire            clr_both;
    wire            clr_mask;
    wire            rd_blocks;

    // ack comes back from the memory fabric, another timing domain
    pend_sync u_ack_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (mem_ack_i),
        .q_o   (ack_s)
    );

    dsc_builder u_dsc (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .load_i  (state_ff == S_IDLE && req_valid_i && req_ready_o && !q_full),
        .bus_i   (req_bus_i),
        .devfn_i (req_devfn_i),
        .pp_i    (req_pp_i),
        .pasid_i (req_pasid_i),
        .addr_i  (req_addr_i),
        .group_index_i  (req_group_index_i),
        .last_in_group_flag_i  (req_last_in_group_flag_i),
        .rdr_i   (req_rdr_i),
        .wrr_i   (req_wrr_i),
        .exr_i   (req_exr_i),
        .pmr_i   (req_pmr_i),
        .dsc_o   (mem_data_o)
    );

    // wrap at the configured last entry, not at the pointer width
    assign tail_inc = (tail_ff == last_ff) ? {PTR_W{1'b0}} : tail_ff + {{(PTR_W-1){1'b0}}, 1'b1}; // R25
    assign q_full   = (tail_inc == head_ff); // R23
    assign q_busy   = (state_ff != S_IDLE);
    // software write-1-to-clear of both status flags
    assign clr_both = reg_wr_i && reg_addr_i == `REG_STATUS
                      && (reg_wdata_i[`ST_PPR_BIT] || !ppr_ff)
                      && (reg_wdata_i[`ST_PRO_BIT] || !pro_ff);
    assign clr_mask = reg_wr_i && reg_addr_i == `REG_EVCTL && !reg_wdata_i[`EV_IM_BIT];
    // new event only when both flags were clear
    assign raise_evt = !ppr_ff && !pro_ff
                       && ((state_ff == S_BUMP) ||
                           (state_ff == S_IDLE && req_valid_i && req_ready_o && q_full)); // R12
    // reads of tail wait for delivery; reads of every register wait for interrupt
    assign rd_blocks = irq_fly_ff || irq_want_ff ||
                       (rd_addr_ff == `REG_TAIL && q_busy); // R18 R19

    // request intake and descriptor write sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= S_IDLE;
            tail_ff      <= {PTR_W{1'b0}};
            mem_wr_o     <= 1'b0;
            mem_idx_o    <= {PTR_W{1'b0}};
            req_ready_o  <= 1'b0;
            last_in_group_flag_drop_ff <= 1'b0;
        end else if (ce_i) begin
            req_ready_o <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    req_ready_o <= !req_ready_o;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        if (q_full) begin
                            last_in_group_flag_drop_ff <= req_last_in_group_flag_i; // dropped, nothing written
                        end else begin
                            mem_wr_o  <= 1'b1; // R16 accepted here
                            mem_idx_o <= tail_ff;
                            state_ff  <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    mem_wr_o <= 1'b0;
                    if (ack_s && !mem_wr_o) begin
                        state_ff <= S_BUMP;
                    end
                end
                S_BUMP: begin
                    tail_ff  <= tail_inc; // R16 delivered after visibility
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // status flags: hardware set wins over software clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            ppr_ff <= 1'b0;
            pro_ff <= 1'b0;
        end else if (ce_i) begin
            if (state_ff == S_BUMP) begin
                ppr_ff <= 1'b1; // R10
            end else if (reg_wr_i && reg_addr_i == `REG_STATUS && reg_wdata_i[`ST_PPR_BIT]) begin
                ppr_ff <= 1'b0;
            end
            if (state_ff == S_IDLE && req_valid_i && req_ready_o && q_full) begin
                pro_ff <= 1'b1; // R11
            end else if (reg_wr_i && reg_addr_i == `REG_STATUS && reg_wdata_i[`ST_PRO_BIT]) begin
                pro_ff <= 1'b0;
            end
        end
    end

    // pending / mask logic and direct interrupt message
    always @(posedge clk_i) begin
        if (rst_i) begin
            ip_ff       <= 1'b0;
            im_ff       <= 1'b1;
            irq_want_ff <= 1'b0;
            irq_fly_ff  <= 1'b0;
            irq_msg_o   <= 1'b0;
        end else if (ce_i) begin
            irq_msg_o <= 1'b0;
            if (reg_wr_i && reg_addr_i == `REG_EVCTL) begin
                im_ff <= reg_wdata_i[`EV_IM_BIT];
            end
            if (raise_evt) begin
                if (im_ff && !clr_mask) begin
                    ip_ff <= 1'b1; // R13
                end else begin
                    irq_want_ff <= 1'b1; // R13
                end
            end else if (ip_ff && clr_mask) begin
                ip_ff       <= 1'b0; // R14
                irq_want_ff <= 1'b1; // R14
            end else if (ip_ff && clr_both) begin
                ip_ff <= 1'b0; // R15
            end
            // tail is bumped on the same edge that raise_evt sets irq_want_ff in S_BUMP;
            // a request taken this cycle is accepted but not yet delivered, so wait
            if (irq_want_ff && !q_busy && !irq_fly_ff && !(req_valid_i && req_ready_o)) begin
                irq_want_ff <= 1'b0;
                irq_msg_o   <= 1'b1; // R17 R20
                irq_fly_ff  <= 1'b1;
            end
            if (irq_fly_ff && irq_done_i) begin
                irq_fly_ff <= 1'b0;
            end
        end
    end

    // configuration registers and invalidation queue check
    always @(posedge clk_i) begin
        if (rst_i) begin
            head_ff  <= {PTR_W{1'b0}};
            last_ff  <= {PTR_W{1'b1}};
            dw_ff    <= 1'b0;
            iq_err_o <= 1'b0;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == `REG_HEAD) begin
                head_ff <= reg_wdata_i[PTR_W-1:0];
            end
            if (reg_wr_i && reg_addr_i == `REG_SIZE) begin
                last_ff <= reg_wdata_i[PTR_W-1:0];
            end
            if (reg_wr_i && reg_addr_i == `REG_IQCFG) begin
                dw_ff <= reg_wdata_i[0];
            end
            if (iq_dsc_valid_i && iq_dsc_type_i == `IQ_TYPE_GRP_RESP && !dw_ff) begin
                iq_err_o <= 1'b1; // R22
            end else if (reg_wr_i && reg_addr_i == `REG_IQERR && reg_wdata_i[0]) begin
                iq_err_o <= 1'b0;
            end
        end
    end

    // reads answer next cycle; every read is held in rd_hold_ff until its ordering is met
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_hold_ff  <= 1'b0;
            rd_addr_ff  <= 4'h0;
            reg_rdata_o <= 32'h0;
        end else if (ce_i) begin
            if (reg_rd_i) begin
                rd_addr_ff <= reg_addr_i;
                rd_hold_ff <= 1'b1;
            end else if (rd_hold_ff && !rd_blocks) begin
                rd_hold_ff <= 1'b0;
            end
            // re-sample only while ordering is pending; frozen once it is met
            if (reg_rd_i || rd_hold_ff) begin
                case (reg_rd_i ? reg_addr_i : rd_addr_ff)
                    `REG_TAIL:   reg_rdata_o <= {{(32-PTR_W){1'b0}}, tail_ff};
                    `REG_HEAD:   reg_rdata_o <= {{(32-PTR_W){1'b0}}, head_ff};
                    `REG_SIZE:   reg_rdata_o <= {{(32-PTR_W){1'b0}}, last_ff};
                    `REG_STATUS: reg_rdata_o <= {30'h0, pro_ff, ppr_ff};
                    `REG_EVCTL:  reg_rdata_o <= {im_ff, ip_ff, 30'h0};
                    `REG_IQCFG:  reg_rdata_o <= {31'h0, dw_ff};
                    `REG_IQERR:  reg_rdata_o <= {30'h0, last_in_group_flag_drop_ff, iq_err_o};
                    default:     reg_rdata_o <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** src/prq_consts.vh ***
// Contract
// R01: every request descriptor carries type code 01h.
// R02: requester identifier holds bus in upper 8 bits, device/function lower.
// R03: pasid present flag 1 with pasid value, else 0 and pasid undefined.
// R04: page address from the message is copied into the address field.
// R05: group index is 9 bits; undefined when read and write flags both 0.
// R06: last-in-group flag set only for final request of its group.
// R07: read and write requested flags mirror the needed access.
// R08: execute flag meaningful only with pasid present and read requested set.
// R09: privilege flag is 1 for supervisor, 0 for user.
// R10: each descriptor written sets the pending request flag.
// R11: a request meeting a full queue sets the overflow flag.
// R12: no new event while pending or overflow flag already set.
// R13: fresh event sets interrupt pending; unmasked sends interrupt and clears it.
// R14: clearing the mask with pending set sends interrupt and clears pending.
// R15: software clearing both flags clears pending without an interrupt.
// R16: accepted at descriptor write issue; delivered once visible and tail bumped.
// R17: all accepted requests delivered before an event interrupt leaves.
// R18: tail register read completes only after all accepted requests delivered.
// R19: status, tail and control reads wait behind an in-flight interrupt.
// R20: event interrupts go out directly, never through interrupt remapping.
// R21: software answers only last-in-group requests, after the whole group.
// R22: group response descriptor in a 128-bit invalidation queue is an error.
// R23: empty when head equals tail; full when tail is one behind head.
// R24: descriptors are 256 bits with type in bits 7:0.
// R25: tail wraps to zero after the last entry of the configured size.
`ifndef PRQ_CONSTS_VH
`define PRQ_CONSTS_VH
`define DSC_TYPE_PAGE_REQ   8'h01
`define DSC_W               256
`define DSC_TYPE_LSB        0
`define DSC_RID_LSB         16
`define DSC_PP_BIT          32
`define DSC_GROUP_INDEX_LSB        33
`define DSC_LAST_IN_GROUP_FLAG_BIT        42
`define DSC_RDR_BIT         43
`define DSC_WRR_BIT         44
`define DSC_EXR_BIT         45
`define DSC_PMR_BIT         46
`define DSC_PASID_LSB       64
`define DSC_ADDR_LSB        128
`define REG_TAIL            4'h0
`define REG_HEAD            4'h1
`define REG_SIZE            4'h2
`define REG_STATUS          4'h3
`define REG_EVCTL           4'h4
`define REG_IQCFG           4'h5
`define REG_IQERR           4'h6
`define ST_PPR_BIT          0
`define ST_PRO_BIT          1
`define EV_IM_BIT           31
`define EV_IP_BIT           30
`define EVCTL_RST           32'h80000000
`define IQ_TYPE_GRP_RESP    7'h09
`endif

// *** src/dsc_builder.v ***
`timescale 1ns/1ps
`default_nettype none
`include "prq_consts.vh"
// packs one page request into the 256-bit queue descriptor, registered
module dsc_builder (
    input  wire         clk_i,
    input  wire         ce_i,
    input  wire         load_i,
    input  wire [7:0]   bus_i,
    input  wire [7:0]   devfn_i,
    input  wire         pp_i,
    input  wire [19:0]  pasid_i,
    input  wire [51:0]  addr_i,
    input  wire [8:0]   group_index_i,
    input  wire         last_in_group_flag_i,
    input  wire         rdr_i,
    input  wire         wrr_i,
    input  wire         exr_i,
    input  wire         pmr_i,
    output reg  [255:0] dsc_o
);
    reg [255:0] nxt_dsc;

    // unused fields stay zero so software sees a stable image
    always @* begin
        nxt_dsc = 256'h0;
        nxt_dsc[`DSC_TYPE_LSB +: 8] = `DSC_TYPE_PAGE_REQ; // R01 R24
        nxt_dsc[`DSC_RID_LSB +: 16] = {bus_i, devfn_i}; // R02
        nxt_dsc[`DSC_PP_BIT] = pp_i; // R03
        nxt_dsc[`DSC_PASID_LSB +: 20] = pp_i ? pasid_i : 20'h0; // R03
        nxt_dsc[`DSC_ADDR_LSB +: 52] = addr_i; // R04
        nxt_dsc[`DSC_GROUP_INDEX_LSB +: 9] = group_index_i; // R05
        nxt_dsc[`DSC_LAST_IN_GROUP_FLAG_BIT] = last_in_group_flag_i; // R06
        nxt_dsc[`DSC_RDR_BIT] = rdr_i; // R07
        nxt_dsc[`DSC_WRR_BIT] = wrr_i; // R07
        nxt_dsc[`DSC_EXR_BIT] = exr_i & pp_i & rdr_i; // R08
        nxt_dsc[`DSC_PMR_BIT] = pmr_i & pp_i; // R09
    end

    always @(posedge clk_i) begin
        if (ce_i && load_i) begin
            dsc_o <= nxt_dsc;
        end
    end
endmodule
`default_nettype wire

// *** src/pend_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a level arriving from another domain
module pend_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire d_i,
    output reg  q_o
);
    reg meta_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            q_o     <= 1'b0;
        end else if (ce_i) begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// *** testbench/page_req_report_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the queue writer through its top-level ports only
module page_req_report_properties #(
    parameter PTR_W = 8
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             req_valid_i,
    input wire logic             req_ready_o,
    input wire logic             mem_wr_o,
    input wire logic [PTR_W-1:0] mem_idx_o,
    input wire logic [255:0]     mem_data_o,
    input wire logic             mem_ack_i,
    input wire logic             irq_msg_o,
    input wire logic             iq_dsc_valid_i,
    input wire logic [6:0]       iq_dsc_type_i,
    input wire logic             iq_err_o,
    input wire logic [3:0]       reg_addr_i,
    input wire logic [31:0]      reg_wdata_i,
    input wire logic             reg_wr_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic             mask_ff;
    logic             dw_ff;
    logic             busy_ff;
    logic             seen_ff;
    logic [PTR_W-1:0] last_ff;
    // shadows of mask, width bit and an unconfirmed write; reset values follow the design
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= 1'b1;
            dw_ff   <= 1'b0;
            busy_ff <= 1'b0;
            seen_ff <= 1'b0;
            last_ff <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == 4'h4) mask_ff <= reg_wdata_i[31];
            if (reg_wr_i && reg_addr_i == 4'h5) dw_ff <= reg_wdata_i[0];
            if (mem_wr_o) begin
                busy_ff <= 1'b1;
                seen_ff <= 1'b1;
                last_ff <= mem_idx_o;
            end else if (mem_ack_i) begin
                busy_ff <= 1'b0;
            end
        end
    end
    AST_TYPE: assert property (mem_wr_o |-> mem_data_o[7:0] == 8'h01)
        else $error("descriptor type code wrong");
    AST_EXEC: assert property (mem_wr_o && mem_data_o[45] |-> mem_data_o[32] && mem_data_o[43])
        else $error("execute flag without pasid and read");
    AST_PRIV: assert property (mem_wr_o && !mem_data_o[32] |-> !mem_data_o[46])
        else $error("privilege flag without pasid");
    AST_CAUSE: assert property (mem_wr_o |-> $past(req_valid_i && req_ready_o))
        else $error("descriptor write without a taken request");
    AST_HOLD: assert property (mem_wr_o |-> !req_ready_o [*3])
        else $error("ready raised while a write is unconfirmed");
    AST_WRAP: assert property (mem_wr_o && seen_ff |-> (mem_idx_o == last_ff + 1'b1) || (mem_idx_o == '0))
        else $error("entry index skipped");
    AST_MASK: assert property (irq_msg_o |-> !mask_ff)
        else $error("interrupt sent while masked");
    AST_DELIV: assert property (irq_msg_o |-> !busy_ff && !mem_wr_o)
        else $error("interrupt ahead of delivery");
    AST_IQERR: assert property (iq_dsc_valid_i && iq_dsc_type_i == 7'h09 && !dw_ff |-> ##[1:2] iq_err_o)
        else $error("wide response in narrow queue not flagged");
endmodule
bind page_req_report page_req_report_properties #(.PTR_W(PTR_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .mem_wr_o(mem_wr_o), .mem_idx_o(mem_idx_o), .mem_data_o(mem_data_o), .mem_ack_i(mem_ack_i),
    .irq_msg_o(irq_msg_o), .iq_dsc_valid_i(iq_dsc_valid_i), .iq_dsc_type_i(iq_dsc_type_i),
    .iq_err_o(iq_err_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i)
);
`default_nettype wire

// *** testbench/mem_fabric_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// memory fabric and interrupt sink beyond the queue writer
module mem_fabric_model (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         mem_wr_i,
    input  wire logic [7:0]   mem_idx_i,
    input  wire logic [255:0] mem_data_i,
    output wire logic         mem_ack_o,
    input  wire logic         irq_msg_i,
    output wire logic         irq_done_o
);
    logic [255:0] mem_q [0:255];
    logic [4:0]   wr_sh_ff;
    logic [1:0]   irq_sh_ff;
    int           nwr = 0;
    // keeps each descriptor so the bench can inspect it
    always @(posedge clk_i) begin
        if (mem_wr_i === 1'b1) begin
            mem_q[mem_idx_i] <= mem_data_i;
            nwr <= nwr + 1;
        end
    end
    // confirmation comes late and lasts three cycles, enough for the two-flop sync
    always @(posedge clk_i) begin
        wr_sh_ff  <= rst_i ? 5'h00 : {wr_sh_ff[3:0], mem_wr_i};
        irq_sh_ff <= rst_i ? 2'h0 : {irq_sh_ff[0], irq_msg_i};
    end
    assign mem_ack_o  = |wr_sh_ff[4:2];
    assign irq_done_o = irq_sh_ff[1];
endmodule
`default_nettype wire

// *** testbench/page_req_report_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module page_req_report_test;
    logic         clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_pp_i = 1'b0, req_last_in_group_flag_i = 1'b0;
    logic         req_rdr_i = 1'b0, req_wrr_i = 1'b0, req_exr_i = 1'b0, req_pmr_i = 1'b0;
    logic         iq_dsc_valid_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]   req_bus_i = 8'h00, req_devfn_i = 8'h00;
    logic [19:0]  req_pasid_i = 20'h00000;
    logic [51:0]  req_addr_i = 52'h0;
    logic [8:0]   req_group_index_i = 9'h000;
    logic [6:0]   iq_dsc_type_i = 7'h00;
    logic [3:0]   reg_addr_i = 4'h0;
    logic [31:0]  reg_wdata_i = 32'h00000000;
    wire          req_ready_o, mem_wr_o, mem_ack_i, irq_msg_o, irq_done_i, iq_err_o;
    wire [7:0]    mem_idx_o;
    wire [255:0]  mem_data_o;
    wire [31:0]   reg_rdata_o;
    logic [255:0] exp_q;
    int           cyc = 0, irqs = 0, seq = 0, mismatches = 0, compares = 0;
    // clock enable tied high; freezing is not exercised
    page_req_report #(.PTR_W(8)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_bus_i(req_bus_i), .req_devfn_i(req_devfn_i), .req_pp_i(req_pp_i), .req_pasid_i(req_pasid_i),
        .req_addr_i(req_addr_i), .req_group_index_i(req_group_index_i), .req_last_in_group_flag_i(req_last_in_group_flag_i), .req_rdr_i(req_rdr_i),
        .req_wrr_i(req_wrr_i), .req_exr_i(req_exr_i), .req_pmr_i(req_pmr_i), .mem_wr_o(mem_wr_o),
        .mem_idx_o(mem_idx_o), .mem_data_o(mem_data_o), .mem_ack_i(mem_ack_i), .irq_msg_o(irq_msg_o),
        .irq_done_i(irq_done_i), .iq_dsc_valid_i(iq_dsc_valid_i), .iq_dsc_type_i(iq_dsc_type_i),
        .iq_err_o(iq_err_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
    );
    mem_fabric_model fab (
        .clk_i(clk_i), .rst_i(rst_i), .mem_wr_i(mem_wr_o), .mem_idx_i(mem_idx_o), .mem_data_i(mem_data_o),
        .mem_ack_o(mem_ack_i), .irq_msg_i(irq_msg_o), .irq_done_o(irq_done_i)
    );
    // 25 ns period
    initial forever #12.5 clk_i = ~clk_i;
    // interrupt tally and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (irq_msg_o === 1'b1) irqs <= irqs + 1;
        if (cyc == 6000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [255:0] s, input logic [255:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        repeat (6) @(negedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    // fields follow a running count so every descriptor differs from the last
    task automatic send(input logic pp, input logic r, input logic x, input logic m, input logic l);
        logic [7:0] n;
        n = 8'h21 + seq[7:0];
        seq++;
        @(posedge clk_i);
        {req_bus_i, req_devfn_i, req_pp_i, req_last_in_group_flag_i, req_rdr_i} <= {n, ~n, pp, l, r};
        {req_wrr_i, req_exr_i, req_pmr_i, req_group_index_i} <= {~r | n[0], x, m, 1'b1, n};
        req_pasid_i <= {n, 12'hABC};
        req_addr_i <= {n, 44'h0123456789A};
        req_valid_i <= 1'b1;
        @(negedge clk_i);
        for (int i = 0; i < 40 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        exp_q = '0;
        exp_q[31:0] = {n, ~n, 8'h00, 8'h01};
        exp_q[46:32] = {m & pp, x & pp & r, ~r | n[0], r, l, 1'b1, n, pp};
        exp_q[83:64] = pp ? {n, 12'hABC} : 20'h00000;
        exp_q[179:128] = {n, 44'h0123456789A};
        repeat (16) @(negedge clk_i);
    endtask
    task automatic iqsend(input logic [6:0] t);
        @(posedge clk_i);
        iq_dsc_valid_i <= 1'b1;
        iq_dsc_type_i <= t;
        @(posedge clk_i);
        iq_dsc_valid_i <= 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
    // four-entry queue: three fill it, the fourth overflows, then head moves and tail wraps
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h4, 32'h80000000);
        rd(4'h3, 32'h0);
        rd(4'h9, 32'h0);
        wr(4'h2, 32'h3);
        send(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(fab.mem_q[0], exp_q);
        rd(4'h3, 32'h1);
        rd(4'h4, 32'hC0000000);
        chk(irqs, 0);
        wr(4'h4, 32'h0);
        chk(irqs, 1);
        rd(4'h4, 32'h0);
        send(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(fab.mem_q[1], exp_q);
        send(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(fab.mem_q[2], exp_q);
        chk(irqs, 1);
        rd(4'h0, 32'h3);
        wr(4'h3, 32'h1);
        send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(fab.nwr, 3);
        rd(4'h3, 32'h2);
        chk(irqs, 2);
        wr(4'h4, 32'h80000000);
        wr(4'h3, 32'h2);
        wr(4'h1, 32'h3);
        send(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        chk(fab.mem_q[3], exp_q);
        rd(4'h4, 32'hC0000000);
        wr(4'h3, 32'h1);
        rd(4'h4, 32'h80000000);
        chk(irqs, 2);
        send(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        chk(fab.mem_q[0], exp_q);
        rd(4'h0, 32'h1);
        iqsend(7'h09);
        chk(iq_err_o, 1'b1);
        wr(4'h6, 32'h1);
        chk(iq_err_o, 1'b0);
        wr(4'h5, 32'h1);
        iqsend(7'h09);
        chk(iq_err_o, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
